// ==== src/cfg_cmd_pkg.sv ====
package cfg_cmd_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_HZ = 100_000_000;
    localparam int SILENCE_UNIT_MS = 100;
    localparam int SILENCE_UNIT_CYCLES = (CLK_HZ / 1000) * SILENCE_UNIT_MS;
    localparam int TICK_W = 24;

    // ==========================================================
    // Command codes
    // ==========================================================
    localparam logic [7:0] CMD_AUTO_ADDR = 8'h3a;
    localparam logic [7:0] CMD_SILENCE = 8'h05;
    localparam logic [7:0] CMD_RATE = 8'h15;
    localparam logic [7:0] CMD_EXIT = 8'h09;

    // ==========================================================
    // Parameter ranges and reset values
    // ==========================================================
    localparam logic [15:0] SILENCE_MIN = 16'h0002;
    localparam logic [15:0] SILENCE_RESET = 16'h000a;
    localparam logic [15:0] RATE_STD_MAX = 16'h0006;
    localparam logic [15:0] RATE_BPS_MIN = 16'h007d;
    localparam logic [1:0] RSP_BYTES_NONE = 2'h0;
    localparam logic [1:0] RSP_BYTES_QUERY = 2'h2;

    // ==========================================================
    // Serial number fields that form the source address
    // ==========================================================
    localparam int SN_HI_A = 29;
    localparam int SN_HI_B = 28;
    localparam int SN_LO_MSB = 13;

    // ==========================================================
    // Rate arithmetic widths
    // ==========================================================
    localparam int NUM_W = 28;
    localparam int DIV_W = 20;
    localparam logic [NUM_W-1:0] CLK_HZ_N = 28'h5f5e100;

    // ==========================================================
    // Carriers and states
    // ==========================================================
    typedef struct packed {
        logic [7:0] code;
        logic has_param;
        logic [15:0] param;
    } cmd_s;

    typedef struct packed {
        logic err;
        logic [1:0] nbytes;
        logic [15:0] data;
    } rsp_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV1 = 2'b01,
        ST_DIV2 = 2'b11,
        ST_DONE = 2'b10
    } conv_e;

    // Standard rate code to bits per second
    function automatic logic [15:0] std_bps(input logic [2:0] code);
        case (code)
            3'h0: std_bps = 16'h04b0;
            3'h1: std_bps = 16'h0960;
            3'h2: std_bps = 16'h12c0;
            3'h3: std_bps = 16'h2580;
            3'h4: std_bps = 16'h4b00;
            3'h5: std_bps = 16'h9600;
            default: std_bps = 16'he100;
        endcase
    endfunction

endpackage

// ==== src/escape_guard.sv ====
`timescale 1ns/10ps
module escape_guard
    import cfg_cmd_pkg::*;
#(
    parameter int UNIT_CYCLES = SILENCE_UNIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic line_active,
    input wire logic char_valid,
    input wire logic [7:0] char_data,
    input wire logic [7:0] escape_char,
    input wire logic [15:0] guard_units,
    output logic enter
);

    // ==========================================================
    // Silence timer after the escape character
    // ==========================================================
    logic armed;
    logic [TICK_W-1:0] tick;
    logic [15:0] units;
    wire is_escape = char_valid && char_data == escape_char;
    wire unit_end = tick == TICK_W'(UNIT_CYCLES - 1);
    wire expired = armed && units == guard_units;

    // Any line activity other than the escape itself disarms the timer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            armed <= 1'b0;
            tick <= '0;
            units <= 16'h0000;
            enter <= 1'b0;
        end else begin
            enter <= 1'b0;
            if (!enable) begin
                armed <= 1'b0;
            end else if (is_escape) begin
                armed <= 1'b1;
                tick <= '0;
                units <= 16'h0000;
            end else if (char_valid || line_active) begin
                armed <= 1'b0;
            end else if (expired) begin
                armed <= 1'b0;
                enter <= 1'b1; // [RL3]
            end else if (armed) begin
                tick <= unit_end ? '0 : tick + 1'b1;
                units <= unit_end ? units + 16'h0001 : units;
            end
        end
    end

endmodule // escape_guard

// ==== src/host_config_command_handler.sv ====
// Function
// RL1: Auto-address command loads source address from serial bits 29, 28, 13..0.
// RL2: Post-escape silence in 100 ms units, range 0x02..0xFFFF, default 0x0A.
// RL3: Command mode entered only after silence following escape lasts the set time.
// RL4: Silence command code 0x05; query returns stored value as two bytes.
// RL5: Rate codes 0..6 map to 1200 through 57600 bps.
// RL6: Rate values 0x7D..0xFFFF are bps; nearest achievable rate is stored.
// RL7: Old UART rate stays in use until exit command mode executes.
// RL8: Host interface rate never alters the radio link data rate.
// RL9: Rate query returns the actually stored value as two bytes.
// RL10: Default host rate equals the factory radio data rate.
// RL11: Host should honour clear-to-send when host rate exceeds radio rate.
// RL12: Parameters are hexadecimal numbers, sent and parsed as such.
// RL13: Command without parameter returns stored value instead of changing it.
`timescale 1ns/10ps
module host_config_command_handler
    import cfg_cmd_pkg::*;
#(
    parameter int UNIT_CYCLES = SILENCE_UNIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serial_input_pin,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic [7:0] escape_sequence_char,
    input wire logic [31:0] factory_serial,
    input wire logic [15:0] factory_rf_rate,
    input wire logic cmd_valid,
    input wire cmd_s cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output rsp_s rsp,
    output logic command_mode,
    output logic [15:0] source_address,
    output logic [DIV_W-1:0] uart_divisor
);

    // ==========================================================
    // State
    // ==========================================================
    logic pin_meta;
    logic pin_sync;
    logic [15:0] guard_time_after_setting;
    logic [15:0] host_rate_setting;
    logic [DIV_W-1:0] pending_divisor;
    conv_e conv_state;
    logic conv_std;
    logic conv_init;
    logic [15:0] conv_code;
    logic init_pending;
    logic guard_enter;
    logic div_start;
    logic div_done;
    logic [NUM_W-1:0] div_num;
    logic [DIV_W-1:0] div_den;
    logic [NUM_W-1:0] div_quot;

    // ==========================================================
    // Command decode
    // ==========================================================
    // Parameters arrive as binary values already parsed from hex text [RL12]
    wire accept = cmd_valid && cmd_ready;
    wire is_auto = cmd.code == CMD_AUTO_ADDR;
    wire is_silence = cmd.code == CMD_SILENCE;
    wire is_rate = cmd.code == CMD_RATE;
    wire is_exit = cmd.code == CMD_EXIT;
    wire silence_ok = cmd.param >= SILENCE_MIN; // [RL2]
    wire rate_is_std = cmd.param <= RATE_STD_MAX;
    wire rate_is_bps = cmd.param >= RATE_BPS_MIN;
    wire rate_write = accept && is_rate && cmd.has_param && (rate_is_std || rate_is_bps);
    wire init_start = init_pending && conv_state == ST_IDLE;
    wire [15:0] start_code = init_start ? factory_rf_rate : cmd.param;
    wire start_std = start_code <= RATE_STD_MAX;
    wire [15:0] start_bps = start_std ? std_bps(start_code[2:0]) : start_code; // [RL5]
    wire [15:0] serial_addr = {factory_serial[SN_HI_A], factory_serial[SN_HI_B],
                               factory_serial[SN_LO_MSB:0]};

    // Busy while a rate conversion runs; commands only in command mode
    assign cmd_ready = command_mode && conv_state == ST_IDLE && !init_pending;

    // ==========================================================
    // Pin synchroniser, the second stage alone feeds the guard
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= serial_input_pin;
            pin_sync <= pin_meta;
        end
    end

    escape_guard #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_guard (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(!command_mode),
        .line_active(!pin_sync),
        .char_valid(rx_char_valid),
        .char_data(rx_char),
        .escape_char(escape_sequence_char),
        .guard_units(guard_time_after_setting),
        .enter(guard_enter)
    );

    // ==========================================================
    // Rate conversion: divisor = round(clk/bps), achieved = round(clk/div)
    // ==========================================================
    // Two passes through one divider trade latency for area
    assign div_start = rate_write || init_start
                       || (conv_state == ST_DIV1 && div_done && !conv_std);
    assign div_num = (conv_state == ST_IDLE)
                     ? CLK_HZ_N + NUM_W'(start_bps[15:1])
                     : CLK_HZ_N + NUM_W'(div_quot[DIV_W-1:1]);
    assign div_den = (conv_state == ST_IDLE) ? DIV_W'(start_bps) : div_quot[DIV_W-1:0];

    rate_divider #(
        .N_W(NUM_W),
        .D_W(DIV_W)
    ) u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .done(div_done),
        .quot(div_quot)
    );

    // Conversion sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            conv_state <= ST_IDLE;
            conv_std <= 1'b0;
            conv_init <= 1'b0;
            conv_code <= 16'h0000;
            init_pending <= 1'b1;
        end else begin
            case (conv_state)
                ST_IDLE: begin
                    if (div_start) begin
                        conv_state <= ST_DIV1;
                        conv_std <= start_std;
                        conv_init <= init_start;
                        conv_code <= start_code;
                        init_pending <= 1'b0;
                    end
                end
                ST_DIV1: begin
                    if (div_done) begin
                        conv_state <= conv_std ? ST_DONE : ST_DIV2;
                    end
                end
                ST_DIV2: begin
                    if (div_done) begin
                        conv_state <= ST_DONE;
                    end
                end
                default: begin
                    conv_state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Setting registers
    // ==========================================================
    // Factory rate is caught after reset release by the init conversion [RL10]
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            guard_time_after_setting <= SILENCE_RESET; // [RL2]
            host_rate_setting <= 16'h0000;
            pending_divisor <= '0;
            source_address <= 16'h0000;
        end else begin
            if (accept && is_silence && cmd.has_param && silence_ok) begin
                guard_time_after_setting <= cmd.param; // [RL2] [RL4]
            end
            if (accept && is_auto) begin
                source_address <= serial_addr; // [RL1]
            end
            if (conv_state == ST_DIV1 && div_done) begin
                pending_divisor <= div_quot[DIV_W-1:0];
                if (conv_std) begin
                    host_rate_setting <= conv_code; // [RL5]
                end
            end
            if (conv_state == ST_DIV2 && div_done) begin
                host_rate_setting <= div_quot[15:0]; // [RL6]
            end
        end
    end

    // Live divisor changes only on exit, or once at start-up [RL7]
    // It drives the host UART only; the radio rate has no path from here [RL8]
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            uart_divisor <= '0;
            command_mode <= 1'b0;
        end else begin
            if (accept && is_exit) begin
                uart_divisor <= pending_divisor; // [RL7]
            end else if (conv_state == ST_DONE && conv_init) begin
                uart_divisor <= pending_divisor; // [RL10]
            end
            // Kept apart from the divisor so an init finish never swallows an entry pulse
            if (accept && is_exit) begin
                command_mode <= 1'b0;
            end else if (guard_enter) begin
                command_mode <= 1'b1; // [RL3]
            end
        end
    end

    // ==========================================================
    // Responses
    // ==========================================================
    // Queries answer next cycle; rate writes answer when conversion ends
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (conv_state == ST_DONE && !conv_init) begin
                rsp_valid <= 1'b1;
                rsp <= '{err: 1'b0, nbytes: RSP_BYTES_NONE, data: 16'h0000};
            end else if (accept && !rate_write) begin
                rsp_valid <= 1'b1;
                rsp <= '{err: 1'b0, nbytes: RSP_BYTES_NONE, data: 16'h0000};
                if (is_silence && !cmd.has_param) begin
                    rsp.nbytes <= RSP_BYTES_QUERY; // [RL4] [RL13]
                    rsp.data <= guard_time_after_setting;
                end else if (is_rate && !cmd.has_param) begin
                    rsp.nbytes <= RSP_BYTES_QUERY; // [RL9] [RL13]
                    rsp.data <= host_rate_setting;
                end else if (is_silence) begin
                    rsp.err <= !silence_ok;
                end else if (is_rate) begin
                    rsp.err <= 1'b1; // [RL6] gap 7..0x7C refused
                end else if (!is_auto && !is_exit) begin
                    rsp.err <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_AUTO_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL1]
        accept && is_auto |=> source_address == {$past(factory_serial[29]),
            $past(factory_serial[28]), $past(factory_serial[13:0])})
        else $error("source address not formed from serial bits");

    AST_SILENCE_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL2]
        accept && is_silence && cmd.has_param && cmd.param < 16'h0002
        |=> $stable(guard_time_after_setting) && rsp_valid && rsp.err)
        else $error("silence below minimum was accepted");

    AST_SILENCE_RESET: assert property (@(posedge clk_sys) // [RL2]
        !rst_n |=> guard_time_after_setting == 16'h000a)
        else $error("silence default wrong after reset");

    AST_ENTER: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
        $rose(command_mode) |-> $past(guard_enter) && $past(!command_mode))
        else $error("command mode entered without silence timeout");

    AST_SILENCE_QUERY: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL4]
        accept && is_silence && !cmd.has_param
        |=> rsp_valid && rsp.nbytes == 2'h2 && rsp.data == guard_time_after_setting)
        else $error("silence query answer wrong");

    AST_STD_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL5]
        conv_state == ST_DIV1 && div_done && conv_std
        |=> host_rate_setting == $past(conv_code) && conv_state == ST_DONE)
        else $error("standard rate code not stored");

    AST_GAP_REFUSED: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
        accept && is_rate && cmd.has_param && cmd.param > 16'h0006 && cmd.param < 16'h007d
        |=> rsp_valid && rsp.err && conv_state == ST_IDLE)
        else $error("rate value in gap not refused");

    AST_RATE_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
        !(accept && is_exit) && !(conv_state == ST_DONE && conv_init)
        |=> $stable(uart_divisor))
        else $error("uart divisor changed before exit");

    AST_EXIT_APPLY: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
        accept && is_exit |=> uart_divisor == $past(pending_divisor) && !command_mode)
        else $error("exit did not apply pending rate");

    AST_RATE_QUERY: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
        accept && is_rate && !cmd.has_param
        |=> rsp_valid && rsp.nbytes == 2'h2 && rsp.data == host_rate_setting)
        else $error("rate query answer wrong");

endmodule // host_config_command_handler

// ==== src/rate_divider.sv ====
`timescale 1ns/10ps
module rate_divider
    import cfg_cmd_pkg::*;
#(
    parameter int N_W = NUM_W,
    parameter int D_W = DIV_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [N_W-1:0] num,
    input wire logic [D_W-1:0] den,
    output logic done,
    output logic [N_W-1:0] quot
);

    // ==========================================================
    // Restoring division, one quotient bit per clock
    // ==========================================================
    logic [D_W:0] rem;
    logic [D_W-1:0] den_q;
    logic [5:0] cnt;
    logic busy;
    logic [D_W:0] shifted;
    logic fits;

    // Remainder stays below den, so D_W+1 bits hold every shift
    assign shifted = {rem[D_W-1:0], quot[N_W-1]};
    assign fits = shifted >= {1'b0, den_q};

    // Caller never passes a zero divisor
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rem <= '0;
            den_q <= '0;
            quot <= '0;
            cnt <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem <= '0;
                den_q <= den;
                quot <= num;
                cnt <= 6'(N_W);
                busy <= 1'b1;
            end else if (busy) begin
                rem <= fits ? shifted - {1'b0, den_q} : shifted;
                quot <= {quot[N_W-2:0], fits};
                cnt <= cnt - 6'h01;
                busy <= cnt != 6'h01;
                done <= cnt == 6'h01;
            end
        end
    end

endmodule // rate_divider

// ==== tb/host_config_command_handler_tb.sv ====
`timescale 1ns/10ps
module host_config_command_handler_tb;
    import cfg_cmd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic serial_input_pin, rx_char_valid, send_escape = 1'b0;
    logic [7:0] rx_char;
    logic [7:0] esc_char = 8'h2b;
    logic [31:0] factory_serial = 32'h2000_1555;
    logic [15:0] factory_rf_rate = 16'h0003;
    logic cmd_valid = 1'b0;
    cmd_s cmd = '0;
    logic cmd_ready, rsp_valid, command_mode;
    rsp_s rsp;
    logic [15:0] source_address;
    logic [DIV_W-1:0] uart_divisor;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    // ==========================================================
    // Clock, timeout and instances
    // ==========================================================
    always #5 clk_sys = ~clk_sys;
    // Whole run needs under a thousand cycles; the ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    host_uart_model host (.clk_sys(clk_sys), .send_escape(send_escape), .escape_char(esc_char),
        .serial_input_pin(serial_input_pin), .rx_char_valid(rx_char_valid), .rx_char(rx_char));
    host_config_command_handler #(.UNIT_CYCLES(10)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .serial_input_pin(serial_input_pin), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .escape_sequence_char(esc_char), .factory_serial(factory_serial),
        .factory_rf_rate(factory_rf_rate), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .command_mode(command_mode),
        .source_address(source_address), .uart_divisor(uart_divisor));

    // ==========================================================
    // Access tasks
    // ==========================================================
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held from a falling edge until the rising edge that takes it
    task automatic do_cmd(input logic [7:0] code, input logic has, input logic [15:0] prm);
        int i;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd = '{code, has, prm};
        i = 0;
        while (cmd_ready !== 1'b1 && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        chk("rsp_valid", 20'h1, {19'h0, rsp_valid});
    endtask

    task automatic q(input logic [7:0] code, input logic [15:0] exp);
        do_cmd(code, 1'b0, 16'h0000);
        chk("query bytes", 20'h2, {18'h0, rsp.nbytes});
        chk("query data", {4'h0, exp}, {4'h0, rsp.data});
    endtask

    task automatic w(input logic [7:0] code, input logic [15:0] prm, input logic e);
        do_cmd(code, 1'b1, prm);
        chk("write err", {19'h0, e}, {19'h0, rsp.err});
    endtask

    // Mode must stay off until the silence after the escape char has run out
    task automatic enter_cmd(input int g);
        int i;
        @(negedge clk_sys);
        send_escape = 1'b1;
        @(negedge clk_sys);
        send_escape = 1'b0;
        repeat (10 * g + 6) @(negedge clk_sys);
        chk("early mode", 20'h0, {19'h0, command_mode});
        i = 0;
        while (command_mode !== 1'b1 && i < 300) begin
            @(negedge clk_sys);
            i++;
        end
        chk("command mode", 20'h1, {19'h0, command_mode});
    endtask

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (100) @(negedge clk_sys);
        chk("mode after reset", 20'h0, {19'h0, command_mode});
        chk("default divisor", 20'h028b1, uart_divisor);
        enter_cmd(10);
        $display("test entry done");
        q(CMD_SILENCE, 16'h000a);
        w(CMD_SILENCE, 16'h0001, 1'b1);
        q(CMD_SILENCE, 16'h000a);
        w(CMD_SILENCE, 16'hffff, 1'b0);
        q(CMD_SILENCE, 16'hffff);
        w(CMD_SILENCE, 16'h0002, 1'b0);
        q(CMD_SILENCE, 16'h0002);
        $display("test silence done");
        q(CMD_RATE, 16'h0003);
        for (int k = 0; k < 7; k++) begin
            w(CMD_RATE, 16'(k), 1'b0);
            q(CMD_RATE, 16'(k));
        end
        w(CMD_RATE, 16'h0007, 1'b1);
        w(CMD_RATE, 16'h007c, 1'b1);
        w(CMD_RATE, 16'h007d, 1'b0);
        q(CMD_RATE, 16'h007d);
        w(CMD_RATE, 16'h4b00, 1'b0);
        q(CMD_RATE, 16'h4b01);
        chk("divisor before exit", 20'h028b1, uart_divisor);
        w(CMD_RATE, 16'h0005, 1'b0);
        $display("test rate done");
        w(CMD_AUTO_ADDR, 16'h0000, 1'b0);
        chk("source address", 20'h09555, {4'h0, source_address});
        w(8'h77, 16'h0000, 1'b1);
        $display("test address done");
        w(CMD_EXIT, 16'h0000, 1'b0);
        chk("mode after exit", 20'h0, {19'h0, command_mode});
        chk("divisor after exit", 20'h00a2c, uart_divisor);
        enter_cmd(2);
        q(CMD_SILENCE, 16'h0002);
        $display("test exit done");
        final_report();
    end
endmodule // host_config_command_handler_tb

// ==== tb/host_uart_model.sv ====
`timescale 1ns/10ps
module host_uart_model (
    input wire logic clk_sys,
    input wire logic send_escape,
    input wire logic [7:0] escape_char,
    output logic serial_input_pin,
    output logic rx_char_valid,
    output logic [7:0] rx_char
);
    logic [3:0] frame_cnt = 4'h0;

    // ==========================================================
    // Escape character framing
    // ==========================================================
    // A frame holds the line low, then raises it for the stop bit before the char is reported,
    // so the two-stage pin synchroniser has settled high when the escape char arms
    // The host sends no payload here, so there is nothing to hold back on clear-to-send
    always @(posedge clk_sys) begin
        if (send_escape && frame_cnt == 4'h0) begin
            frame_cnt <= 4'ha;
        end else if (frame_cnt != 4'h0) begin
            frame_cnt <= frame_cnt - 4'h1;
        end
        rx_char_valid <= (frame_cnt == 4'h1);
    end

    // Idle high; stale char data is inverted so it never looks valid
    assign serial_input_pin = (frame_cnt < 4'h4);
    assign rx_char = rx_char_valid ? escape_char : ~escape_char;
endmodule // host_uart_model
